// ==== rtl/acmp_defs.svh ====
// register offsets, field positions, reset values and timing counts of the comparator block
`ifndef ACMP_DEFS_SVH
`define ACMP_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets on the avalon bus
`define ACMP_OFS_SFC 8'h00
`define ACMP_OFS_CSR 8'h04
`define ACMP_OFS_STS 8'h08
`define ACMP_OFS_MSK 8'h0C

////////////////////////////////////////////////////////////////////////////////
// shared function control fields
`define ACMP_SFC_MUX_EN 3
`define ACMP_SFC_RSVD 4

// comparator control and status fields
`define ACMP_CSR_PWR_OFF 7
`define ACMP_CSR_BG_SEL 6
`define ACMP_CSR_OUT 5
`define ACMP_CSR_FLAG 4
`define ACMP_CSR_IE 3
`define ACMP_CSR_CAP_EN 2
`define ACMP_CSR_MODE_HI 1
`define ACMP_CSR_MODE_LO 0

// interrupt status and mask fields
`define ACMP_STS_EVENT 0
`define ACMP_STS_TOGGLE 1
`define ACMP_STS_W 2

////////////////////////////////////////////////////////////////////////////////
// reset values
`define ACMP_SFC_RST 8'h00
`define ACMP_MODE_RST 2'h0
`define ACMP_STS_RST 2'h0
`define ACMP_MSK_RST 2'h0

// synchroniser depth, giving one to two cycles of latency
`define ACMP_SYNC_STAGES 2

`endif

// ==== rtl/acmp_pkg.sv ====
// types shared by the comparator control block
package acmp_pkg;

  typedef enum logic [1:0] {
    EV_TOGGLE = 2'h0,
    EV_RESERVED = 2'h1,
    EV_FALL = 2'h2,
    EV_RISE = 2'h3
  } evt_mode_t;

endpackage

// ==== rtl/comparator_front.sv ====
// input selection and the comparison itself, modelled on sampled level codes
module comparator_front #(
  parameter int VW = 10,
  parameter int NCH = 8
) (
  // selected levels
  input wire logic [VW-1:0] positive_input_pin,
  input wire logic [VW-1:0] negative_input_pin,
  input wire logic [NCH*VW-1:0] converter_input_pins,
  input wire logic [VW-1:0] bandgap_level,
  // selection and power controls
  input wire logic bandgap_positive_select,
  input wire logic negative_input_mux_enable,
  input wire logic converter_enable,
  input wire logic [2:0] channel_select,
  input wire logic comparator_power_off,
  // result
  output logic raw_result,
  output logic neg_from_converter
);

  logic [VW-1:0] pin_arr [NCH];
  logic [VW-1:0] pos_level;
  logic [VW-1:0] neg_level;

  for (genvar g = 0; g < NCH; g++) begin : g_pins
    assign pin_arr[g] = converter_input_pins[g*VW +: VW];
  end

  // the converter owns its multiplexer while it runs, so only an idle converter lends it
  assign neg_from_converter = negative_input_mux_enable & ~converter_enable;
  assign neg_level = neg_from_converter ? pin_arr[channel_select] : negative_input_pin;
  assign pos_level = bandgap_positive_select ? bandgap_level : positive_input_pin;
  // an unpowered comparator reads as low
  assign raw_result = ~comparator_power_off & (pos_level > neg_level);

endmodule

// ==== rtl/comparator_sync.sv ====
// two-stage synchroniser for the comparator result
module comparator_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and out
  input wire logic d,
  output logic q
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;

endmodule

// ==== rtl/analog_comparator_control.sv ====
// comparator control: input selection, synchronised output, event flag, avalon registers
`include "acmp_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - result high when positive exceeds negative
// - result synchronised, one to two cycles late
// - output status bit five, read only
// - idle converter lends pins 0-7 to negative
// - otherwise dedicated negative pin is used
// - mux enable at bit three, resets zero
// - bit six selects bandgap for positive input
// - bit seven powers comparator off
// - matching output transition sets event flag
// - vector or written one clears flag
// - request needs flag, enable and global enable
// - mode 00 toggle, 10 fall, 11 rise
// - bit two routes output to capture
// - converter enable blocks negative multiplexing
module analog_comparator_control #(
  parameter int VW = 10,
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // input levels as sampled codes
  input wire logic [VW-1:0] positive_input_pin,
  input wire logic [VW-1:0] negative_input_pin,
  input wire logic [NCH*VW-1:0] converter_input_pins,
  input wire logic [VW-1:0] bandgap_level,
  // converter state
  input wire logic converter_enable,
  input wire logic [2:0] channel_select,
  // cpu interrupt side
  input wire logic cpu_global_ie,
  input wire logic vector_ack,
  output logic comparator_irq_req,
  output logic irq,
  // timer capture and power
  output logic capture_input,
  output logic comparator_power_off
);

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  logic wait_q;
  logic [31:0] rdata_q;
  logic [7:0] sfc_q;
  logic pwr_off_q;
  logic bg_sel_q;
  logic flag_q;
  logic flag_d;
  logic ie_q;
  logic cap_en_q;
  acmp_pkg::evt_mode_t mode_q;
  logic [`ACMP_STS_W-1:0] sts_q;
  logic [`ACMP_STS_W-1:0] sts_d;
  logic [`ACMP_STS_W-1:0] msk_q;
  logic prev_q;
  logic req_q;
  logic irq_q;
  logic cap_q;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode

  wire logic req = read | write;
  wire logic take = req & wait_q;
  wire logic wr_acc = write & ~wait_q & byteenable[0];
  wire logic rd_acc = read & ~wait_q;
  wire logic sel_sfc = address == `ACMP_OFS_SFC;
  wire logic sel_csr = address == `ACMP_OFS_CSR;
  wire logic sel_sts = address == `ACMP_OFS_STS;
  wire logic sel_msk = address == `ACMP_OFS_MSK;
  wire logic wr_sfc = wr_acc & sel_sfc;
  wire logic wr_csr = wr_acc & sel_csr;
  wire logic wr_msk = wr_acc & sel_msk;
  wire logic rd_sts = rd_acc & sel_sts;
  wire logic [7:0] wd = writedata[7:0];

  ////////////////////////////////////////////////////////////////////////////////
  // analog front and synchroniser

  logic raw_result;
  logic sync_out;
  logic neg_from_converter;

  comparator_front #(
    .VW(VW),
    .NCH(NCH)
  ) u_front (
    .positive_input_pin(positive_input_pin),
    .negative_input_pin(negative_input_pin),
    .converter_input_pins(converter_input_pins),
    .bandgap_level(bandgap_level),
    .bandgap_positive_select(bg_sel_q),
    .negative_input_mux_enable(sfc_q[`ACMP_SFC_MUX_EN]),
    .converter_enable(converter_enable),
    .channel_select(channel_select),
    .comparator_power_off(pwr_off_q),
    .raw_result(raw_result),
    .neg_from_converter(neg_from_converter)
  );

  comparator_sync u_sync (
    .clk(clk),
    .rstn(rstn),
    .d(raw_result),
    .q(sync_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // edge detection and event selection

  wire logic rise = sync_out & ~prev_q;
  wire logic fall = ~sync_out & prev_q;
  wire logic toggle = rise | fall;
  wire logic hit_toggle = (mode_q == acmp_pkg::EV_TOGGLE) & toggle;
  wire logic hit_fall = (mode_q == acmp_pkg::EV_FALL) & fall;
  wire logic hit_rise = (mode_q == acmp_pkg::EV_RISE) & rise;
  // the reserved code matches nothing
  wire logic event_hit = hit_toggle | hit_fall | hit_rise;
  wire logic flag_clr = vector_ack | (wr_csr & wd[`ACMP_CSR_FLAG]);

  // a new event wins over a clear in the same cycle
  assign flag_d = event_hit | (flag_q & ~flag_clr);

  // only bits already returned by the read are cleared, so later events survive
  wire logic [`ACMP_STS_W-1:0] sts_set = {toggle, event_hit};
  wire logic [`ACMP_STS_W-1:0] sts_clr = rd_sts ? rdata_q[`ACMP_STS_W-1:0] : `ACMP_STS_RST;
  assign sts_d = sts_set | (sts_q & ~sts_clr);

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  wire logic [7:0] csr_rd = {pwr_off_q, bg_sel_q, sync_out, flag_q, ie_q, cap_en_q, mode_q};
  wire logic [7:0] sfc_rd = sfc_q & ~(8'h01 << `ACMP_SFC_RSVD);
  wire logic [7:0] sts_rd = {6'h00, sts_q};
  wire logic [7:0] msk_rd = {6'h00, msk_q};
  wire logic [7:0] rd_mux = sel_sfc ? sfc_rd :
                            sel_csr ? csr_rd :
                            sel_sts ? sts_rd :
                            sel_msk ? msk_rd : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, data ready at the accepting edge

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~take;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_q <= 32'h00000000;
    end else if (take && read) begin
      rdata_q <= {24'h000000, rd_mux};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // software registers

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sfc_q <= `ACMP_SFC_RST;
    end else if (wr_sfc) begin
      sfc_q <= wd & ~(8'h01 << `ACMP_SFC_RSVD);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pwr_off_q <= 1'b0;
      bg_sel_q <= 1'b0;
      ie_q <= 1'b0;
      cap_en_q <= 1'b0;
      mode_q <= acmp_pkg::EV_TOGGLE;
    end else if (wr_csr) begin
      pwr_off_q <= wd[`ACMP_CSR_PWR_OFF];
      bg_sel_q <= wd[`ACMP_CSR_BG_SEL];
      ie_q <= wd[`ACMP_CSR_IE];
      cap_en_q <= wd[`ACMP_CSR_CAP_EN];
      mode_q <= acmp_pkg::evt_mode_t'(wd[`ACMP_CSR_MODE_HI:`ACMP_CSR_MODE_LO]);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msk_q <= `ACMP_MSK_RST;
    end else if (wr_msk) begin
      msk_q <= wd[`ACMP_STS_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // event state and outputs

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_q <= 1'b0;
      flag_q <= 1'b0;
      sts_q <= `ACMP_STS_RST;
    end else begin
      prev_q <= sync_out;
      flag_q <= flag_d;
      sts_q <= sts_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_q <= 1'b0;
      irq_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      req_q <= flag_q & ie_q & cpu_global_ie;
      irq_q <= |(sts_q & msk_q);
      // no path at all to the capture unit while routing is off
      cap_q <= cap_en_q & sync_out;
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;
  assign comparator_irq_req = req_q;
  assign irq = irq_q;
  assign capture_input = cap_q;
  assign comparator_power_off = pwr_off_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // the first two edges after a release still show the synchroniser's reset value
  a_sync_latency: assert property ($past(rstn, 2) |->
    sync_out == $past(raw_result, 2))
    else $error("comparator output not two cycles behind raw result");

  a_out_readback: assert property (take && read && sel_csr |=>
    rdata_q[`ACMP_CSR_OUT] == $past(sync_out))
    else $error("output status bit does not show synchronised result");

  // checks the selected pin level itself, not just the select expression
  a_neg_mux_sel: assert property (!pwr_off_q && !bg_sel_q |-> raw_result ==
    ((sfc_q[`ACMP_SFC_MUX_EN] && !converter_enable) ?
    (positive_input_pin > converter_input_pins[channel_select*VW +: VW]) :
    (positive_input_pin > negative_input_pin)))
    else $error("negative input source chosen wrongly");

  a_mux_en_write: assert property (wr_sfc |=>
    sfc_q[`ACMP_SFC_MUX_EN] == $past(wd[`ACMP_SFC_MUX_EN]))
    else $error("mux enable not stored on write");

  a_power_off: assert property (pwr_off_q |-> !raw_result)
    else $error("unpowered comparator reports high");

  a_event_sets: assert property (event_hit |=> flag_q)
    else $error("matching edge did not set event flag");

  a_flag_clear: assert property (flag_q && flag_clr && !event_hit |=> !flag_q)
    else $error("event flag survived a clear");

  a_flag_hold: assert property (flag_q && !flag_clr |=> flag_q)
    else $error("event flag dropped without a clear");

  a_irq_request: assert property (comparator_irq_req ==
    $past(flag_q && ie_q && cpu_global_ie))
    else $error("interrupt request does not follow flag and enables");

  a_reserved_mode: assert property (mode_q == acmp_pkg::EV_RESERVED && !flag_q
    && !vector_ack |=> !flag_q)
    else $error("reserved mode set the event flag");

  a_capture_route: assert property (!cap_en_q |=> !capture_input)
    else $error("capture driven while routing is off");

  a_one_wait: assert property (take |=> !waitrequest ##1 waitrequest)
    else $error("bus answer not exactly one wait cycle");

  c_rise_event: cover property (mode_q == acmp_pkg::EV_RISE && rise ##1 flag_q);
  c_fall_event: cover property (mode_q == acmp_pkg::EV_FALL && fall ##1 flag_q);
  c_vector_clear: cover property (flag_q && vector_ack ##1 !flag_q);
  c_converter_pin: cover property (neg_from_converter && channel_select == 3'h7);
  c_reserved_edge: cover property (mode_q == acmp_pkg::EV_RESERVED && toggle);

endmodule

// ==== bench/acmp_far_model.sv ====
// far side model: analog pin levels and the timer capture front end
module acmp_far_model #(
  parameter int VW = 10,
  parameter int NCH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // levels towards the comparator
  output logic [VW-1:0] pos_level,
  output logic [VW-1:0] neg_level,
  output logic [NCH*VW-1:0] pin_levels,
  output logic [VW-1:0] bg_level,
  // timer capture side
  input wire logic capture_input,
  input wire logic capture_irq_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic cap_q;
  int unsigned capture_irqs;

  ////////////////////////////////////////////////////////////////////////////////
  // fixed ladder of pin levels, so every channel has a distinct level
  initial begin
    pos_level = VW'(0);
    neg_level = VW'(16'h0100);
    bg_level = VW'(16'h0080);
    for (int g = 0; g < NCH; g++) begin
      pin_levels[g*VW +: VW] = VW'(16'h0040 + g * 16'h0060);
    end
  end

  task automatic set_pos(input logic [VW-1:0] v);
    pos_level <= v;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // rising edge select only; noise canceller not modelled
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cap_q <= 1'b0;
      capture_irqs <= 0;
    end else begin
      cap_q <= capture_input;
      if (capture_input && !cap_q && capture_irq_enable) begin
        capture_irqs <= capture_irqs + 1;
      end
    end
  end
endmodule

// ==== bench/analog_comparator_control_tb.sv ====
// self-checking bench for the comparator control block
`include "acmp_defs.svh"
module analog_comparator_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic bg; logic mux; logic cen; logic [2:0] ch; logic out;} row_t;
  // pos 200, dedicated neg 100, bandgap 080, pin g at 040 + g*060
  localparam row_t ROWS [12] = '{
    '{1'b0, 1'b1, 1'b0, 3'h0, 1'b1}, '{1'b0, 1'b1, 1'b0, 3'h1, 1'b1},
    '{1'b0, 1'b1, 1'b0, 3'h2, 1'b1}, '{1'b0, 1'b1, 1'b0, 3'h3, 1'b1},
    '{1'b0, 1'b1, 1'b0, 3'h4, 1'b1}, '{1'b0, 1'b1, 1'b0, 3'h5, 1'b0},
    '{1'b0, 1'b1, 1'b0, 3'h6, 1'b0}, '{1'b0, 1'b1, 1'b0, 3'h7, 1'b0},
    '{1'b1, 1'b1, 1'b0, 3'h0, 1'b1}, '{1'b1, 1'b0, 1'b0, 3'h0, 1'b0},
    '{1'b0, 1'b1, 1'b1, 3'h5, 1'b1}, '{1'b0, 1'b0, 1'b0, 3'h6, 1'b1}};
  logic clk, rstn, read, write, converter_enable, cpu_global_ie, vector_ack, cap_ie;
  logic waitrequest, comparator_irq_req, irq, capture_input, comparator_power_off;
  logic [7:0] address;
  logic [7:0] r;
  logic [31:0] writedata, readdata;
  logic [3:0] byteenable;
  logic [2:0] channel_select;
  logic [9:0] pos, neg, bg;
  logic [79:0] pins;
  int n_errors, num_checks, i, m;

  analog_comparator_control u_dut (.clk(clk), .rstn(rstn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .positive_input_pin(pos), .negative_input_pin(neg),
    .converter_input_pins(pins), .bandgap_level(bg), .converter_enable(converter_enable),
    .channel_select(channel_select), .cpu_global_ie(cpu_global_ie), .vector_ack(vector_ack),
    .comparator_irq_req(comparator_irq_req), .irq(irq), .capture_input(capture_input),
    .comparator_power_off(comparator_power_off));
  acmp_far_model u_far (.clk(clk), .rstn(rstn), .pos_level(pos), .neg_level(neg),
    .pin_levels(pins), .bg_level(bg), .capture_input(capture_input),
    .capture_irq_enable(cap_ie));

  always #25 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      n_errors++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // request held until waitrequest is sampled low; one idle edge after release
  // no cycle count is assumed: the watchdog ends only a wait that never finishes
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                     input logic [3:0] be, output logic [7:0] rd);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= {24'h000000, wd};
    byteenable <= be;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'hF, r);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] e);
    bus(1'b0, a, 8'h00, 4'hF, r);
    chk(r & msk, e);
  endtask

  task automatic lvl(input logic [9:0] v);
    u_far.set_pos(v);
    tick(6);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end

  initial begin
    {clk, rstn, read, write, converter_enable, cpu_global_ie, vector_ack, cap_ie} = 8'h00;
    address = 8'h00;
    writedata = 32'h00000000;
    byteenable = 4'h0;
    channel_select = 3'h0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(`ACMP_OFS_SFC, 8'hFF, 8'h00);
    rd_chk(`ACMP_OFS_CSR, 8'hFF, 8'h00);
    rd_chk(`ACMP_OFS_STS, 8'hFF, 8'h00);
    rd_chk(`ACMP_OFS_MSK, 8'hFF, 8'h00);
    wr(`ACMP_OFS_SFC, 8'hFF);
    rd_chk(`ACMP_OFS_SFC, 8'hFF, 8'hEF);
    wr(`ACMP_OFS_SFC, 8'h00);
    bus(1'b1, `ACMP_OFS_SFC, 8'h08, 4'h0, r);
    rd_chk(`ACMP_OFS_SFC, 8'hFF, 8'h00);
    wr(8'h10, 8'hFF);
    rd_chk(8'h10, 8'hFF, 8'h00);
    wr(`ACMP_OFS_CSR, 8'h20);
    rd_chk(`ACMP_OFS_CSR, 8'hFF, 8'h00);
    $display("test done: register access");
    u_far.set_pos(10'h200);
    for (i = 0; i < 12; i++) begin
      wr(`ACMP_OFS_SFC, {4'h0, ROWS[i].mux, 3'h0});
      converter_enable <= ROWS[i].cen;
      channel_select <= ROWS[i].ch;
      wr(`ACMP_OFS_CSR, {1'b0, ROWS[i].bg, 6'h00});
      tick(3);
      rd_chk(`ACMP_OFS_CSR, 8'h20, {2'h0, ROWS[i].out, 5'h00});
    end
    $display("test done: input selection");
    for (m = 0; m < 4; m++) begin
      lvl(10'h000);
      wr(`ACMP_OFS_CSR, {6'h04, 2'(m)});
      bus(1'b0, `ACMP_OFS_STS, 8'h00, 4'hF, r);
      lvl(10'h200);
      rd_chk(`ACMP_OFS_CSR, 8'h10, (m == 0 || m == 3) ? 8'h10 : 8'h00);
      wr(`ACMP_OFS_CSR, {6'h04, 2'(m)});
      lvl(10'h000);
      rd_chk(`ACMP_OFS_CSR, 8'h10, (m == 0 || m == 2) ? 8'h10 : 8'h00);
      rd_chk(`ACMP_OFS_STS, 8'h03, (m == 1) ? 8'h02 : 8'h03);
      rd_chk(`ACMP_OFS_STS, 8'h03, 8'h00);
    end
    $display("test done: event modes");
    wr(`ACMP_OFS_MSK, 8'h01);
    cpu_global_ie <= 1'b1;
    wr(`ACMP_OFS_CSR, 8'h1B);
    bus(1'b0, `ACMP_OFS_STS, 8'h00, 4'hF, r);
    lvl(10'h200);
    chk(comparator_irq_req, 1'b1);
    chk(irq, 1'b1);
    cpu_global_ie <= 1'b0;
    tick(2);
    chk(comparator_irq_req, 1'b0);
    cpu_global_ie <= 1'b1;
    tick(2);
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    tick(2);
    chk(comparator_irq_req, 1'b0);
    rd_chk(`ACMP_OFS_CSR, 8'h10, 8'h00);
    chk(irq, 1'b1);
    rd_chk(`ACMP_OFS_STS, 8'h03, 8'h03);
    tick(2);
    chk(irq, 1'b0);
    wr(`ACMP_OFS_MSK, 8'h00);
    lvl(10'h000);
    chk(irq, 1'b0);
    wr(`ACMP_OFS_MSK, 8'h02);
    tick(2);
    chk(irq, 1'b1);
    bus(1'b0, `ACMP_OFS_STS, 8'h00, 4'hF, r);
    tick(2);
    chk(irq, 1'b0);
    $display("test done: interrupts");
    wr(`ACMP_OFS_CSR, 8'h03);
    wr(`ACMP_OFS_CSR, 8'h04);
    cap_ie <= 1'b1;
    lvl(10'h200);
    chk(capture_input, 1'b1);
    lvl(10'h000);
    chk(capture_input, 1'b0);
    chk(u_far.capture_irqs, 32'h1);
    wr(`ACMP_OFS_CSR, 8'h00);
    lvl(10'h200);
    chk(capture_input, 1'b0);
    $display("test done: capture route");
    // power off reads back at bit seven and drops the output bit; power on restores it
    wr(`ACMP_OFS_CSR, 8'h80);
    tick(4);
    chk(comparator_power_off, 1'b1);
    rd_chk(`ACMP_OFS_CSR, 8'hA0, 8'h80);
    wr(`ACMP_OFS_CSR, 8'h00);
    tick(4);
    rd_chk(`ACMP_OFS_CSR, 8'hA0, 8'h20);
    $display("test done: power off");
    wr(`ACMP_OFS_SFC, 8'h08);
    wr(`ACMP_OFS_CSR, 8'h80);
    rstn <= 1'b0;
    tick(2);
    chk(waitrequest, 1'b1);
    chk(comparator_power_off, 1'b0);
    rstn <= 1'b1;
    tick(1);
    rd_chk(`ACMP_OFS_SFC, 8'hFF, 8'h00);
    $display("test done: second reset");
    complete_run();
  end
endmodule
